// ---- ipcb_pkg.sv ----
// Purpose: Constants for the interrupt priority configuration bank
// Assumes: 16-bit registers, one per aligned 32-bit Avalon word
`default_nettype none
package ipcb_pkg;
	localparam int NUM_REGS = 11;
	localparam int NUM_SRC = 23;
	localparam logic [2:0] LEVEL_RESET = 3'h4;
	localparam logic [2:0] LEVEL_OFF = 3'h0;
	localparam logic [3:0] ADDR_EXT1 = 4'h0;
	localparam logic [3:0] ADDR_TMR4 = 4'h1;
	localparam logic [3:0] ADDR_SER2 = 4'h2;
	localparam logic [3:0] ADDR_SPI2 = 4'h3;
	localparam logic [3:0] ADDR_CAP = 4'h4;
	localparam logic [3:0] ADDR_CMP5 = 4'h5;
	localparam logic [3:0] ADDR_PAR = 4'h6;
	localparam logic [3:0] ADDR_TWI2 = 4'h7;
	localparam logic [3:0] ADDR_EXT34 = 4'h8;
	localparam logic [3:0] ADDR_CAL = 4'h9;
	localparam logic [3:0] ADDR_CRC = 4'ha;
	// Implemented field bits per register, index = word address
	localparam logic [15:0] MASK_EXT1 = 16'h0007;
	localparam logic [15:0] MASK_TMR4 = 16'h7770;
	localparam logic [15:0] MASK_SER2 = 16'h7777;
	localparam logic [15:0] MASK_SPI2 = 16'h0077;
	localparam logic [15:0] MASK_CAP = 16'h7770;
	localparam logic [15:0] MASK_CMP5 = 16'h0070;
	localparam logic [15:0] MASK_PAR = 16'h0070;
	localparam logic [15:0] MASK_TWI2 = 16'h0770;
	localparam logic [15:0] MASK_EXT34 = 16'h0770;
	localparam logic [15:0] MASK_CAL = 16'h0700;
	localparam logic [15:0] MASK_CRC = 16'h7770;
	// Reset word: 100 in every implemented field
	localparam logic [15:0] RESET_PATTERN = 16'h4444;
	// Field bit offsets inside a register
	localparam int POS_A = 12;
	localparam int POS_B = 8;
	localparam int POS_C = 4;
	localparam int POS_D = 0;
endpackage
`default_nettype wire

// ---- ipcb_arbiter.sv ----
// Purpose: Picks the highest-level pending enabled source
// Assumes: Lowest index wins a tie
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
module ipcb_arbiter #(
	parameter int NSRC = 23
) (
	input wire logic [NSRC*3-1:0] levels,
	input wire logic [NSRC-1:0] pending,
	output logic reqValid,
	output logic [4:0] reqIndex,
	output logic [2:0] reqLevel
);
	always_comb begin
		reqValid = 1'b0;
		reqIndex = 5'h0;
		reqLevel = 3'h0;
		for (int i = 0; i < NSRC; i++) begin
			// Level 000 never wins since strict greater-than is used
			if (pending[i] && (levels[i*3 +: 3] > reqLevel)) begin
				reqValid = 1'b1;
				reqIndex = 5'(i);
				reqLevel = levels[i*3 +: 3];
			end
		end
	end
endmodule
`default_nettype wire

// ---- ipcb_bank.sv ----
// Purpose: Priority field register bank with Avalon-MM slave
// Assumes: Word addressed, waitrequest low one cycle after request
// Notes: Levels are the raw 3-bit codes, 001 lowest, 111 highest
`timescale 1ns/1ps
`default_nettype none
module ipcb_bank (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [22:0] srcPending,
	output logic [68:0] srcLevels,
	output logic arbValid,
	output logic [4:0] arbIndex,
	output logic [2:0] arbLevel
);
	logic [15:0] bank_reg [ipcb_pkg::NUM_REGS];
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	logic [15:0] maskTab [ipcb_pkg::NUM_REGS];
	wire logic request = avs_read | avs_write;
	wire logic hit = avs_address < 4'(ipcb_pkg::NUM_REGS);
	wire logic [15:0] laneMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	assign maskTab[0] = ipcb_pkg::MASK_EXT1;
	assign maskTab[1] = ipcb_pkg::MASK_TMR4;
	assign maskTab[2] = ipcb_pkg::MASK_SER2;
	assign maskTab[3] = ipcb_pkg::MASK_SPI2;
	assign maskTab[4] = ipcb_pkg::MASK_CAP;
	assign maskTab[5] = ipcb_pkg::MASK_CMP5;
	assign maskTab[6] = ipcb_pkg::MASK_PAR;
	assign maskTab[7] = ipcb_pkg::MASK_TWI2;
	assign maskTab[8] = ipcb_pkg::MASK_EXT34;
	assign maskTab[9] = ipcb_pkg::MASK_CAL;
	assign maskTab[10] = ipcb_pkg::MASK_CRC;

	// One wait cycle, then the access completes
	assign avs_waitrequest = request & ~ack_reg;
	wire logic doWrite = avs_write & ack_reg & hit;

	genvar g;
	generate
		for (g = 0; g < ipcb_pkg::NUM_REGS; g++) begin : gRegs
			wire logic sel = doWrite && (avs_address == 4'(g));
			wire logic [15:0] wmask = laneMask & maskTab[g];
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					bank_reg[g] <= ipcb_pkg::RESET_PATTERN & maskTab[g];
				end else if (sel) begin
					// Unused bits stay zero
					bank_reg[g] <= (bank_reg[g] & ~wmask) | (avs_writedata[15:0] & wmask);
				end
			end
		end
	endgenerate

	assign rdata_next = (avs_read && hit) ? {16'h0, bank_reg[avs_address]} : 32'h0;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg <= request & ~ack_reg;
			rdata_reg <= rdata_next;
		end
	end
	assign avs_readdata = rdata_reg;

	// Source order: index = position in the flat level vector
	assign srcLevels = {
		bank_reg[ipcb_pkg::ADDR_CRC][ipcb_pkg::POS_C +: 3], // 22 serial1 error
		bank_reg[ipcb_pkg::ADDR_CRC][ipcb_pkg::POS_B +: 3], // 21 serial2 error
		bank_reg[ipcb_pkg::ADDR_CRC][ipcb_pkg::POS_A +: 3], // 20 checksum
		bank_reg[ipcb_pkg::ADDR_CAL][ipcb_pkg::POS_B +: 3], // 19 calendar
		bank_reg[ipcb_pkg::ADDR_EXT34][ipcb_pkg::POS_C +: 3], // 18 ext3
		bank_reg[ipcb_pkg::ADDR_EXT34][ipcb_pkg::POS_B +: 3], // 17 ext4
		bank_reg[ipcb_pkg::ADDR_TWI2][ipcb_pkg::POS_C +: 3], // 16 two-wire slave
		bank_reg[ipcb_pkg::ADDR_TWI2][ipcb_pkg::POS_B +: 3], // 15 two-wire master
		bank_reg[ipcb_pkg::ADDR_PAR][ipcb_pkg::POS_C +: 3], // 14 parallel
		bank_reg[ipcb_pkg::ADDR_CMP5][ipcb_pkg::POS_C +: 3], // 13 compare5
		bank_reg[ipcb_pkg::ADDR_CAP][ipcb_pkg::POS_C +: 3], // 12 capture3
		bank_reg[ipcb_pkg::ADDR_CAP][ipcb_pkg::POS_B +: 3], // 11 capture4
		bank_reg[ipcb_pkg::ADDR_CAP][ipcb_pkg::POS_A +: 3], // 10 capture5
		bank_reg[ipcb_pkg::ADDR_SPI2][ipcb_pkg::POS_D +: 3], // 9 spi fault
		bank_reg[ipcb_pkg::ADDR_SPI2][ipcb_pkg::POS_C +: 3], // 8 spi event
		bank_reg[ipcb_pkg::ADDR_SER2][ipcb_pkg::POS_D +: 3], // 7 timer5
		bank_reg[ipcb_pkg::ADDR_SER2][ipcb_pkg::POS_C +: 3], // 6 ext2
		bank_reg[ipcb_pkg::ADDR_SER2][ipcb_pkg::POS_B +: 3], // 5 serial2 receive
		bank_reg[ipcb_pkg::ADDR_SER2][ipcb_pkg::POS_A +: 3], // 4 serial2 transmit
		bank_reg[ipcb_pkg::ADDR_TMR4][ipcb_pkg::POS_C +: 3], // 3 compare3
		bank_reg[ipcb_pkg::ADDR_TMR4][ipcb_pkg::POS_B +: 3], // 2 compare4
		bank_reg[ipcb_pkg::ADDR_TMR4][ipcb_pkg::POS_A +: 3], // 1 timer4
		bank_reg[ipcb_pkg::ADDR_EXT1][ipcb_pkg::POS_D +: 3] // 0 ext1
	};

	ipcb_arbiter #(
		.NSRC(ipcb_pkg::NUM_SRC)
	) uArb (
		.levels(srcLevels),
		.pending(srcPending),
		.reqValid(arbValid),
		.reqIndex(arbIndex),
		.reqLevel(arbLevel)
	);
endmodule
`default_nettype wire

// ---- ipcb_bank_monitor.sv ----
// Purpose: Port checks for the priority bank
// Assumes: One wait cycle per request
// Notes: Bound to ipcb_bank below
`timescale 1ns/1ps
`default_nettype none
module ipcb_bank_monitor (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [22:0] srcPending,
	input wire logic [68:0] srcLevels,
	input wire logic arbValid,
	input wire logic [4:0] arbIndex,
	input wire logic [2:0] arbLevel
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire logic req = avs_read | avs_write;
	wire logic rdOk = avs_read & ~avs_waitrequest;
	chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
		else $error("no wait cycle");
	chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	chk_upper_zero: assert property (rdOk |-> avs_readdata[31:16] == 16'h0)
		else $error("upper bits set");
	chk_unmapped_zero: assert property (rdOk && avs_address > 4'ha
		|-> avs_readdata == 32'h0)
		else $error("unmapped read");
	chk_ext1_unused: assert property (rdOk && avs_address == 4'h0
		|-> avs_readdata[15:3] == 13'h0)
		else $error("ext1 unused bits");
	chk_cal_unused: assert property (rdOk && avs_address == 4'h9
		|-> (avs_readdata[15:0] & 16'hf8ff) == 16'h0)
		else $error("calendar unused bits");
	chk_off_never: assert property (arbValid
		|-> arbLevel != 3'h0 && srcPending[arbIndex])
		else $error("bad winner");
	chk_idle_arb: assert property (srcPending == 23'h0 |-> !arbValid)
		else $error("winner without pending");
	chk_write_next: assert property (avs_write && !avs_waitrequest && avs_address == 4'h0
		&& avs_byteenable[0] |=> srcLevels[2:0] == $past(avs_writedata[2:0]))
		else $error("write not applied");
	chk_reset_level: assert property ($fell(sys_rst) |-> srcLevels == {23{3'h4}})
		else $error("reset level");
endmodule
bind ipcb_bank ipcb_bank_monitor i_mon (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .srcPending, .srcLevels,
	.arbValid, .arbIndex, .arbLevel);
`default_nettype wire

// ---- tb.sv ----
// Purpose: Register and arbitration tests for the priority bank
// Assumes: Avalon master with waitrequest
// Notes: Expected values from field masks
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, arbValid;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [22:0] srcPending;
	logic [68:0] srcLevels;
	logic [4:0] arbIndex;
	logic [2:0] arbLevel;
	int failures = 0;
	int tests_run = 0;
	logic [15:0] mask [12] = '{16'h0007, 16'h7770, 16'h7777, 16'h0077, 16'h7770, 16'h0070,
		16'h0070, 16'h0770, 16'h0770, 16'h0700, 16'h7770, 16'h0000};
	// Per-source levels after writing 1234 to every register, source 22 first
	logic [68:0] expLev = {3'h3, 3'h2, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h3, 3'h2,
		3'h1, 3'h4, 3'h3, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h2, 3'h1, 3'h4};
	ipcb_bank i_ipcb_bank (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .srcPending, .srcLevels, .arbValid,
		.arbIndex, .arbLevel);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task test_done;
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, s, e);
		end
	endtask
	// Bus access held until waitrequest is seen low
	task acc(input bit w, input logic [3:0] a, input logic [15:0] d, output logic [31:0] r);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {16'h0, d};
		if (w)
			avs_write <= 1'b1;
		else
			avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	initial begin
		#200000;
		failures++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata, srcPending} = '0;
		avs_byteenable = 4'hf;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			acc(1'b0, 4'(i), 16'h0, q);
			chk(q, {16'h0, mask[i] & 16'h4444});
		end
		for (int i = 0; i < 12; i++) begin
			acc(1'b1, 4'(i), 16'hffff, q);
			acc(1'b0, 4'(i), 16'h0, q);
			chk(q, {16'h0, mask[i]});
		end
		for (int i = 0; i < 11; i++)
			acc(1'b1, 4'(i), 16'h1234, q);
		@(posedge mclk);
		for (int i = 0; i < 23; i++)
			chk(32'(srcLevels[3*i +: 3]), 32'(expLev[3*i +: 3]));
		avs_byteenable <= 4'h2;
		acc(1'b1, 4'h1, 16'h0, q);
		avs_byteenable <= 4'hf;
		acc(1'b0, 4'h1, 16'h0, q);
		chk(q, 32'h0030);
		acc(1'b1, 4'h0, 16'h0, q);
		acc(1'b1, 4'h2, 16'h1000, q);
		srcPending <= 23'h21;
		repeat (2) @(posedge mclk);
		#1;
		chk(32'({arbValid, arbIndex, arbLevel}), 32'h0);
		@(posedge mclk);
		srcPending <= 23'h31;
		repeat (2) @(posedge mclk);
		#1;
		chk(32'({arbValid, arbIndex, arbLevel}), 32'({1'b1, 5'h04, 3'h1}));
		acc(1'b1, 4'h0, 16'h7, q);
		repeat (2) @(posedge mclk);
		#1;
		chk(32'({arbValid, arbIndex, arbLevel}), 32'({1'b1, 5'h00, 3'h7}));
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		acc(1'b0, 4'h4, 16'h0, q);
		chk(q, 32'h4440);
		chk(32'({arbValid, arbIndex, arbLevel}), 32'({1'b1, 5'h00, 3'h4}));
		test_done();
	end
endmodule
`default_nettype wire
